// ==== common/sfcm_consts.vh ====
`ifndef SFCM_CONSTS_VH
`define SFCM_CONSTS_VH

// Flash instruction codes
`define SFCM_CODE_LATCH_SET 8'h06
`define SFCM_CODE_LATCH_CLEAR 8'h04
`define SFCM_CODE_IDENT_READ 8'h9F
`define SFCM_CODE_STATE_READ 8'h05
`define SFCM_CODE_STATE_WRITE 8'h01
`define SFCM_CODE_READ 8'h03
`define SFCM_CODE_FAST_READ 8'h0B
`define SFCM_CODE_PAGE_PROGRAM 8'h02
`define SFCM_CODE_REGION_CLEAR 8'hD8
`define SFCM_CODE_FULL_CLEAR 8'hC7
`define SFCM_CODE_DEEP_SLEEP 8'hB9
`define SFCM_CODE_WAKE_SIG 8'hAB

// Host command selectors
`define SFCM_SEL_W 4
`define SFCM_SEL_LATCH_SET 4'h0
`define SFCM_SEL_LATCH_CLEAR 4'h1
`define SFCM_SEL_IDENT_READ 4'h2
`define SFCM_SEL_STATE_READ 4'h3
`define SFCM_SEL_STATE_WRITE 4'h4
`define SFCM_SEL_READ 4'h5
`define SFCM_SEL_FAST_READ 4'h6
`define SFCM_SEL_PAGE_PROGRAM 4'h7
`define SFCM_SEL_REGION_CLEAR 4'h8
`define SFCM_SEL_FULL_CLEAR 4'h9
`define SFCM_SEL_DEEP_SLEEP 4'hA
`define SFCM_SEL_WAKE_SIG 4'hB

// Byte layout and fill values
`define SFCM_BYTE_W 8
`define SFCM_MSB 7
`define SFCM_BITS_PER_BYTE 4'h8
`define SFCM_DUMMY_BYTE 8'hFF
`define SFCM_LEN_W 16
`define SFCM_CNT_W 16

// Reset values
`define SFCM_RST_SEL_N 1'b1
`define SFCM_RST_SCLK 1'b1
`define SFCM_RST_SOUT 1'b1

`endif

// ==== hdl/sfcm_master.v ====
// Operation
// - Link runs SPI mode 3: clock idles high, clock phase one.
// - Outgoing bit changes on a falling serial clock edge.
// - Incoming bit is sampled on a rising serial clock edge.
// - Bytes shift most significant bit first, both directions.
// - Serial clock held high whenever no transfer runs.
// - Configurable wait after select low before first falling edge.
// - Configurable wait after last rising edge before select high.
// - Order: select low, set-up, bytes, hold, select high.
// - Read code 03h, fast read code 0Bh.
// - Latch set code 06h, latch clear code 04h.
// - Identification 9Fh, status read 05h, status write 01h.
// - Page program 02h, sector erase D8h, full erase C7h.
// - Deep sleep B9h and wake ABh optional, off by default.
// - Response bytes clocked in within the same selected transaction.
// - Select value preset high before enabling its output, then high.
// - Enable: pins high, hand pins to serial function, then set rate.
// - Disable: stop serial, input plain, output and clock pins high.
// - Byte order kept: n-th link byte is n-th host byte.
// - Clock generated internally; two data wires; select separate output.
// - Outgoing order: instruction, address bytes, then data or status.
`timescale 1ns/1ps
`default_nettype none
`include "sfcm_consts.vh"

module sfcm_master #(
  parameter [`SFCM_CNT_W-1:0] SETUP_CYC = 16'h0002,
  parameter [`SFCM_CNT_W-1:0] HOLD_CYC = 16'h0002,
  parameter [0:0] PWR_CMDS_EN = 1'b0
) (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_nrst,
  input wire i_ce,
  // Link control
  input wire i_link_en,
  input wire [`SFCM_CNT_W-1:0] i_half_div,
  output wire o_link_on,
  // Transaction request
  input wire i_start,
  input wire [`SFCM_SEL_W-1:0] i_cmd_sel,
  input wire [`SFCM_LEN_W-1:0] i_tx_len,
  input wire [`SFCM_LEN_W-1:0] i_rx_len,
  output wire o_busy,
  output reg o_cmd_err,
  // Transmit bytes
  input wire i_tx_valid,
  input wire [`SFCM_BYTE_W-1:0] i_tx_data,
  output wire o_tx_ready,
  // Received bytes
  output reg o_rx_valid,
  output reg [`SFCM_BYTE_W-1:0] o_rx_data,
  // Flash pins
  output reg o_sclk,
  output reg o_serial_out_pin,
  input wire i_serial_in_pin,
  output reg o_sel_n,
  output reg o_sel_oe
);

  localparam [7:0] S_OFF = 8'h01;
  localparam [7:0] S_PREP = 8'h02;
  localparam [7:0] S_HAND = 8'h04;
  localparam [7:0] S_RATE = 8'h08;
  localparam [7:0] S_IDLE = 8'h10;
  localparam [7:0] S_SETUP = 8'h20;
  localparam [7:0] S_SHIFT = 8'h40;
  localparam [7:0] S_HOLD = 8'h80;

  reg [7:0] state_q;
  reg [`SFCM_CNT_W-1:0] cnt_q;
  reg [`SFCM_CNT_W-1:0] rate_q;
  reg [`SFCM_BYTE_W-1:0] tx_sh_q;
  reg [`SFCM_BYTE_W-1:0] rx_sh_q;
  reg [3:0] bit_q;
  reg [`SFCM_LEN_W-1:0] tx_rem_q;
  reg [`SFCM_LEN_W-1:0] rx_rem_q;
  reg rx_phase_q;
  reg serial_on_q;
  reg sin_meta_q;
  reg sin_sync_q;

  // Instruction code for a host selector
  function [`SFCM_BYTE_W-1:0] cmd_code;
    input [`SFCM_SEL_W-1:0] sel;
    begin
      case (sel)
        `SFCM_SEL_LATCH_SET: cmd_code = `SFCM_CODE_LATCH_SET;
        `SFCM_SEL_LATCH_CLEAR: cmd_code = `SFCM_CODE_LATCH_CLEAR;
        `SFCM_SEL_IDENT_READ: cmd_code = `SFCM_CODE_IDENT_READ;
        `SFCM_SEL_STATE_READ: cmd_code = `SFCM_CODE_STATE_READ;
        `SFCM_SEL_STATE_WRITE: cmd_code = `SFCM_CODE_STATE_WRITE;
        `SFCM_SEL_READ: cmd_code = `SFCM_CODE_READ;
        `SFCM_SEL_FAST_READ: cmd_code = `SFCM_CODE_FAST_READ;
        `SFCM_SEL_PAGE_PROGRAM: cmd_code = `SFCM_CODE_PAGE_PROGRAM;
        `SFCM_SEL_REGION_CLEAR: cmd_code = `SFCM_CODE_REGION_CLEAR;
        `SFCM_SEL_FULL_CLEAR: cmd_code = `SFCM_CODE_FULL_CLEAR;
        `SFCM_SEL_DEEP_SLEEP: cmd_code = `SFCM_CODE_DEEP_SLEEP;
        `SFCM_SEL_WAKE_SIG: cmd_code = `SFCM_CODE_WAKE_SIG;
        default: cmd_code = `SFCM_DUMMY_BYTE;
      endcase
    end
  endfunction

  // Selector accepted by this build
  function sel_ok;
    input [`SFCM_SEL_W-1:0] sel;
    input pwr_en;
    begin
      if (sel == `SFCM_SEL_DEEP_SLEEP || sel == `SFCM_SEL_WAKE_SIG)
        sel_ok = pwr_en;
      else
        sel_ok = (sel < `SFCM_SEL_DEEP_SLEEP);
    end
  endfunction

  // One less, resting at zero
  function [`SFCM_CNT_W-1:0] dec_cnt;
    input [`SFCM_CNT_W-1:0] val;
    begin
      if (val == {`SFCM_CNT_W{1'b0}})
        dec_cnt = {`SFCM_CNT_W{1'b0}};
      else
        dec_cnt = val - 16'h0001;
    end
  endfunction

  // Some count still left
  function is_nonzero;
    input [`SFCM_CNT_W-1:0] val;
    begin
      is_nonzero = (val != {`SFCM_CNT_W{1'b0}});
    end
  endfunction

  // Byte moved one place up, new bit at the bottom
  function [`SFCM_BYTE_W-1:0] shift_in;
    input [`SFCM_BYTE_W-1:0] val;
    input bit_in;
    begin
      shift_in = {val[`SFCM_MSB-1:0], bit_in};
    end
  endfunction

  wire tick = !is_nonzero(cnt_q);
  wire byte_done = (bit_q == `SFCM_BITS_PER_BYTE);
  wire at_boundary = (state_q == S_SHIFT) && o_sclk && byte_done && tick;
  wire start_ok = sel_ok(i_cmd_sel, PWR_CMDS_EN);
  // A zero divider runs one cycle per half period
  wire [`SFCM_CNT_W-1:0] half_load = dec_cnt(rate_q);

  assign o_link_on = serial_on_q;
  assign o_busy = (state_q == S_SETUP) || (state_q == S_SHIFT) || (state_q == S_HOLD);
  // Frozen cycles take no byte
  assign o_tx_ready = i_ce && at_boundary && is_nonzero(tx_rem_q);

  // Serial input synchroniser
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      sin_meta_q <= 1'b1;
      sin_sync_q <= 1'b1;
    end
    else if (i_ce)
    begin
      sin_meta_q <= i_serial_in_pin;
      sin_sync_q <= sin_meta_q;
    end
  end

  // Select value is already high when its driver turns on
  always @(posedge i_clk)
  begin
    if (!i_nrst)
      o_sel_oe <= 1'b0;
    else if (i_ce)
      o_sel_oe <= 1'b1;
  end

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_q <= S_OFF;
      cnt_q <= {`SFCM_CNT_W{1'b0}};
      rate_q <= {`SFCM_CNT_W{1'b0}};
      tx_sh_q <= `SFCM_DUMMY_BYTE;
      rx_sh_q <= {`SFCM_BYTE_W{1'b0}};
      bit_q <= 4'h0;
      tx_rem_q <= {`SFCM_LEN_W{1'b0}};
      rx_rem_q <= {`SFCM_LEN_W{1'b0}};
      rx_phase_q <= 1'b0;
      serial_on_q <= 1'b0;
      o_cmd_err <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data <= {`SFCM_BYTE_W{1'b0}};
      o_sclk <= `SFCM_RST_SCLK;
      o_serial_out_pin <= `SFCM_RST_SOUT;
      o_sel_n <= `SFCM_RST_SEL_N;
    end
    else if (i_ce)
    begin
      o_cmd_err <= 1'b0;
      o_rx_valid <= 1'b0;
      if (!tick)
        cnt_q <= dec_cnt(cnt_q);
      case (state_q)
        S_OFF:
        begin
          o_sel_n <= 1'b1;
          serial_on_q <= 1'b0;
          o_sclk <= 1'b1;
          o_serial_out_pin <= 1'b1;
          if (i_link_en)
            state_q <= S_PREP;
        end
        S_PREP:
        begin
          o_sclk <= 1'b1;
          o_serial_out_pin <= 1'b1;
          state_q <= S_HAND;
        end
        S_HAND:
        begin
          serial_on_q <= 1'b1;
          state_q <= S_RATE;
        end
        S_RATE:
        begin
          // Rate taken only once the pins belong to the link
          rate_q <= i_half_div;
          state_q <= S_IDLE;
        end
        S_IDLE:
        begin
          o_sclk <= 1'b1;
          o_sel_n <= 1'b1;
          if (!i_link_en)
          begin
            state_q <= S_OFF;
          end
          // A refused selector leaves select high
          else if (i_start && !start_ok)
          begin
            o_cmd_err <= 1'b1;
          end
          else if (i_start)
          begin
            o_sel_n <= 1'b0;
            cnt_q <= SETUP_CYC;
            tx_sh_q <= cmd_code(i_cmd_sel);
            bit_q <= 4'h0;
            tx_rem_q <= i_tx_len;
            rx_rem_q <= i_rx_len;
            rx_phase_q <= 1'b0;
            state_q <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          // Select low, clock still high
          if (tick)
            state_q <= S_SHIFT;
        end
        S_SHIFT:
        begin
          if (tick)
          begin
            if (o_sclk && byte_done)
            begin
              if (is_nonzero(tx_rem_q))
              begin
                // Waits with clock high until the host offers a byte
                if (i_tx_valid)
                begin
                  tx_sh_q <= i_tx_data;
                  tx_rem_q <= dec_cnt(tx_rem_q);
                  bit_q <= 4'h0;
                end
              end
              else if (is_nonzero(rx_rem_q))
              begin
                // Ones go out while the flash answers
                tx_sh_q <= `SFCM_DUMMY_BYTE;
                rx_rem_q <= dec_cnt(rx_rem_q);
                rx_phase_q <= 1'b1;
                bit_q <= 4'h0;
              end
              else
              begin
                // Clock has stood high for a half period already
                cnt_q <= HOLD_CYC;
                state_q <= S_HOLD;
              end
            end
            else if (o_sclk)
            begin
              // Falling edge: present next bit
              o_sclk <= 1'b0;
              o_serial_out_pin <= tx_sh_q[`SFCM_MSB];
              tx_sh_q <= shift_in(tx_sh_q, 1'b1);
              cnt_q <= half_load;
            end
            else
            begin
              // Rising edge: capture incoming bit
              // Pin seen two cycles late; half period must be three or more
              o_sclk <= 1'b1;
              rx_sh_q <= shift_in(rx_sh_q, sin_sync_q);
              bit_q <= bit_q + 4'h1;
              cnt_q <= half_load;
              if (rx_phase_q && bit_q == `SFCM_BITS_PER_BYTE - 4'h1)
              begin
                o_rx_valid <= 1'b1;
                o_rx_data <= shift_in(rx_sh_q, sin_sync_q);
              end
            end
          end
        end
        S_HOLD:
        begin
          // Select rises once the hold count runs out
          o_sclk <= 1'b1;
          if (tick)
          begin
            o_sel_n <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_OFF;
        end
      endcase
    end
  end

endmodule // sfcm_master
`default_nettype wire

// ==== verif/sfcm_master_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfcm_master_monitor #(
  parameter [15:0] SETUP_CYC = 16'h0002,
  parameter [15:0] HOLD_CYC = 16'h0002
) (
  // Watched ports
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic o_busy,
  input wire logic o_cmd_err,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic o_sclk,
  input wire logic o_serial_out_pin,
  input wire logic o_sel_n,
  input wire logic o_sel_oe,
  input wire logic o_link_on
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_sclk_idle: assert property (!o_busy |-> o_sclk)
    else $error("clock low while idle");
  a_sel_idle: assert property (!o_busy |-> o_sel_n)
    else $error("select low while idle");
  // Figures below assume the default waits of 2
  a_setup_wait: assert property ($fell(o_sel_n) |-> o_sclk [*3])
    else $error("setup wait too short");
  a_hold_wait: assert property ($rose(o_sel_n) |-> $past(o_sclk) && $past(o_sclk, 2)
    && $past(o_sclk, 3)) else $error("hold wait too short");
  a_out_on_fall: assert property ($changed(o_serial_out_pin) && !o_sel_n &&
    !$past(o_sel_n) |-> $fell(o_sclk)) else $error("data moved off falling edge");
  a_rx_after_rise: assert property (o_rx_valid |-> o_sclk && !$past(o_sclk))
    else $error("byte not after rising edge");
  a_ready_high: assert property (o_tx_ready |-> o_sclk && !o_sel_n)
    else $error("ready off a byte boundary");
  a_err_idle: assert property (o_cmd_err |-> !o_busy && $past(i_start))
    else $error("refusal without start");
  a_start_cause: assert property ($rose(o_busy) |-> $past(i_start) && !o_sel_n)
    else $error("busy without start");
  a_oe_preset: assert property ($rose(o_sel_oe) |-> o_sel_n)
    else $error("select enabled low");
  a_link_pins: assert property (!o_link_on |-> o_sclk && o_serial_out_pin)
    else $error("pins low with link down");
endmodule // sfcm_master_monitor
bind sfcm_master sfcm_master_monitor #(.SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC)) u_mon (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_start(i_start), .o_busy(o_busy),
  .o_cmd_err(o_cmd_err), .o_tx_ready(o_tx_ready), .o_rx_valid(o_rx_valid),
  .o_sclk(o_sclk), .o_serial_out_pin(o_serial_out_pin), .o_sel_n(o_sel_n),
  .o_sel_oe(o_sel_oe), .o_link_on(o_link_on));
`default_nettype wire

// ==== verif/sfcm_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sfcm_flash_model (
  // Flash pins
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  output logic o_miso
);
  logic [7:0] sh;
  logic [7:0] b;
  logic [7:0] got[$];
  int ib;
  int ob;
  initial o_miso = 1'b1;
  always @(negedge i_sel_n)
  begin
    ib = 0;
    ob = 0;
    got.delete();
  end
  always @(posedge i_sclk)
  begin
    if (!i_sel_n)
    begin
      sh = {sh[6:0], i_mosi};
      ib++;
      if (ib % 8 == 0) got.push_back(sh);
    end
  end
  // Link byte n answers 3C plus n
  always @(negedge i_sclk)
  begin
    if (!i_sel_n)
    begin
      b = 8'h3C + 8'(ob / 8);
      o_miso = b[7 - ob % 8];
      ob++;
    end
  end
  // Released line shows the inverse
  always @(posedge i_sel_n) o_miso = ~o_miso;
endmodule // sfcm_flash_model
`default_nettype wire

// ==== verif/spi_flash_command_master_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h seen %h", nm, e, a); end end
module spi_flash_command_master_tb_top;
  logic i_clk, i_nrst, i_link_en, i_start, i_tx_valid;
  logic [3:0] i_cmd_sel;
  logic [15:0] i_tx_len, i_rx_len;
  logic [7:0] i_tx_data;
  wire o_link_on, o_busy, o_cmd_err, o_tx_ready, o_rx_valid, o_sclk, o_sout, o_sel_n, o_sel_oe;
  wire miso;
  wire [7:0] o_rx_data;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [7:0] codes[10] = '{8'h06, 8'h04, 8'h9F, 8'h05, 8'h01, 8'h03, 8'h0B, 8'h02, 8'hD8, 8'hC7};
  sfcm_master #(.SETUP_CYC(16'h0002), .HOLD_CYC(16'h0002), .PWR_CMDS_EN(1'b0)) dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_link_en(i_link_en),
    .i_half_div(16'h0004), .o_link_on(o_link_on), .i_start(i_start), .i_cmd_sel(i_cmd_sel),
    .i_tx_len(i_tx_len), .i_rx_len(i_rx_len), .o_busy(o_busy), .o_cmd_err(o_cmd_err),
    .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data), .o_tx_ready(o_tx_ready),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .o_sclk(o_sclk),
    .o_serial_out_pin(o_sout), .i_serial_in_pin(miso), .o_sel_n(o_sel_n), .o_sel_oe(o_sel_oe));
  sfcm_flash_model flash (.i_sclk(o_sclk), .i_sel_n(o_sel_n), .i_mosi(o_sout), .o_miso(miso));
  initial forever #5 i_clk = ~i_clk;
  task automatic give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wait_link;
    int n;
    for (n = 0; n < 20 && o_link_on !== 1'b1; n++) tick();
    if (n == 20)
    begin
      n_mismatch++;
      give_verdict();
    end
    repeat (2) tick();
  endtask
  task automatic t_reset;
    repeat (6) tick();
    `CHK("sclk", 1'b1, o_sclk)
    `CHK("oe", 1'b0, o_sel_oe)
    i_nrst = 1'b1;
    tick();
    `CHK("oe", 1'b1, o_sel_oe)
    `CHK("sel", 1'b1, o_sel_n)
    wait_link();
  endtask
  task automatic t_txn(input logic [3:0] sel, input logic [7:0] code, input int ntx, input int nrx);
    int n;
    int k;
    int r;
    logic acc;
    k = 0;
    r = 0;
    i_start = 1'b1;
    i_cmd_sel = sel;
    i_tx_len = 16'(ntx);
    i_rx_len = 16'(nrx);
    tick();
    i_start = 1'b0;
    for (n = 0; n < 4000; n++)
    begin
      i_tx_valid = (k < ntx);
      i_tx_data = 8'h90 + 8'(k);
      @(negedge i_clk);
      if (o_busy !== 1'b1) break;
      acc = o_tx_ready === 1'b1 && i_tx_valid;
      if (o_rx_valid === 1'b1) begin `CHK("rx", 8'h3C + 8'(1 + ntx + r), o_rx_data) r++; end
      tick();
      if (acc) k++;
    end
    i_tx_valid = 1'b0;
    if (n == 4000)
    begin
      n_mismatch++;
      give_verdict();
    end
    `CHK("nrx", nrx, r)
    `CHK("nbytes", 1 + ntx + nrx, flash.got.size())
    `CHK("code", code, flash.got[0])
    for (n = 0; n < ntx; n++) `CHK("tx", 8'h90 + 8'(n), flash.got[1 + n])
    tick();
  endtask
  task automatic t_refuse(input logic [3:0] sel);
    i_start = 1'b1;
    i_cmd_sel = sel;
    tick();
    i_start = 1'b0;
    @(negedge i_clk);
    `CHK("err", 1'b1, o_cmd_err)
    `CHK("busy", 1'b0, o_busy)
    tick();
  endtask
  task automatic t_link;
    i_link_en = 1'b0;
    repeat (2) tick();
    `CHK("link", 1'b0, o_link_on)
    `CHK("pins", 2'b11, {o_sclk, o_sout})
    i_start = 1'b1;
    tick();
    i_start = 1'b0;
    tick();
    `CHK("sel", 1'b1, o_sel_n)
    i_link_en = 1'b1;
    wait_link();
    `CHK("pins", 2'b11, {o_sclk, o_sout})
  endtask
  initial
  begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    i_link_en = 1'b1;
    i_start = 1'b0;
    i_tx_valid = 1'b0;
    i_cmd_sel = 4'h0;
    i_tx_len = 16'h0000;
    i_rx_len = 16'h0000;
    i_tx_data = 8'h00;
    t_reset();
    for (int i = 0; i < 10; i++) t_txn(4'(i), codes[i], i % 4, (i + 1) % 3);
    t_refuse(4'hA);
    t_refuse(4'hB);
    t_refuse(4'hF);
    t_link();
    t_txn(4'h5, 8'h03, 3, 2);
    give_verdict();
  end
endmodule // spi_flash_command_master_tb_top
`default_nettype wire
